/* File: verilog/trim_bank_pkg.sv */
// Purpose: Constants for the converter offset and gain trim register bank
// Assumes: Byte addresses as printed, 16-bit register port data
// Notes:   Offset trims are 12 bits wide in 16-bit registers, the fine gain register 8 bits
package trim_bank_pkg;

  localparam int ADDR_W  = 12;
  localparam int DATA_W  = 16;
  localparam int TRIM_W  = 12;
  localparam int GAIN_W  = 5;
  localparam int GAIN_REG_W = 8;
  localparam int OFFSET_REGS = 4;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_A_SINGLE_FIRST  = 12'h348;
  localparam logic [ADDR_W-1:0] OFS_A_SINGLE_SECOND = 12'h34A;
  localparam logic [ADDR_W-1:0] OFS_B_FIRST         = 12'h34C;
  localparam logic [ADDR_W-1:0] OFS_B_SECOND        = 12'h34E;
  localparam logic [ADDR_W-1:0] OFS_A_BANK0_GAIN    = 12'h350;

  // Field positions
  localparam int TRIM_LSB     = 0;
  localparam int TRIM_MSB     = 11;
  localparam int TRIM_RSV_LSB = 12;
  localparam int GAIN_LSB     = 0;
  localparam int GAIN_MSB     = 4;

  // Values after reset, before the fuse copy lands
  localparam logic [DATA_W-1:0]     OFFSET_RESET = 16'h0000;
  localparam logic [GAIN_REG_W-1:0] GAIN_RESET   = 8'h00;
  localparam logic [3:0]            TRIM_RSV_CLR = 4'h0;
  localparam logic [2:0]            GAIN_RSV_CLR = 3'h0;

  // Index of each offset trim in the storage array, plus the gain and unmapped decode slots
  typedef enum logic [2:0] {
    SLOT_A_FIRST  = 3'b000,
    SLOT_A_SECOND = 3'b001,
    SLOT_B_FIRST  = 3'b010,
    SLOT_B_SECOND = 3'b011,
    SLOT_GAIN     = 3'b100,
    SLOT_NONE     = 3'b111
  } slot_type;

endpackage

/* File: verilog/trim_bank.sv */
// Purpose: Offset and fine gain trim registers feeding the converter cores
// Assumes: One clock, async active-low reset, plain register port
// Notes:   Fuse defaults are copied in on the first enabled cycle after reset
`timescale 1ns/100ps
module trim_bank (
  input  wire logic                               CLK_SYS,
  input  wire logic                               RESET_N,
  input  wire logic                               CE,
  input  wire logic [trim_bank_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [trim_bank_pkg::DATA_W-1:0]   WDATA,
  input  wire logic                               WR,
  input  wire logic                               RD,
  output logic      [trim_bank_pkg::DATA_W-1:0]   RDATA,
  input  wire logic [trim_bank_pkg::TRIM_W-1:0]   FUSE_A_FIRST,
  input  wire logic [trim_bank_pkg::TRIM_W-1:0]   FUSE_A_SECOND,
  input  wire logic [trim_bank_pkg::TRIM_W-1:0]   FUSE_B_FIRST,
  input  wire logic [trim_bank_pkg::TRIM_W-1:0]   FUSE_B_SECOND,
  input  wire logic [trim_bank_pkg::GAIN_W-1:0]   FUSE_A_BANK0_GAIN,
  input  wire logic                               FG_CAL_EN,
  input  wire logic                               DUAL_MODE,
  input  wire logic                               CORE_A_SECOND_INPUT,
  input  wire logic                               CORE_A_PHASE90,
  input  wire logic                               CORE_B_SECOND_INPUT,
  output logic      [trim_bank_pkg::TRIM_W-1:0]   CORE_A_OFFSET,
  output logic      [trim_bank_pkg::TRIM_W-1:0]   CORE_B_OFFSET,
  output logic      [trim_bank_pkg::GAIN_W-1:0]   CORE_A_BANK0_GAIN,
  output logic                                    FUSE_LOADED
);
  import trim_bank_pkg::*;

  logic [DATA_W-1:0]     off_q [OFFSET_REGS];
  logic [DATA_W-1:0]     off_d [OFFSET_REGS];
  logic [GAIN_REG_W-1:0] gain_q;
  logic [GAIN_REG_W-1:0] gain_d;
  logic                  loaded_q;
  logic                  loaded_d;
  logic [DATA_W-1:0]     rdata_q;
  logic [DATA_W-1:0]     rdata_d;
  logic [TRIM_W-1:0]     a_off_q;
  logic [TRIM_W-1:0]     a_off_d;
  logic [TRIM_W-1:0]     b_off_q;
  logic [TRIM_W-1:0]     b_off_d;
  logic [GAIN_W-1:0]     a_gain_q;
  logic [GAIN_W-1:0]     a_gain_d;
  slot_type              slot;

  // Address decode shared by the write and read paths
  always_comb begin
    unique case (ADDR)
      OFS_A_SINGLE_FIRST:  slot = SLOT_A_FIRST;
      OFS_A_SINGLE_SECOND: slot = SLOT_A_SECOND;
      OFS_B_FIRST:         slot = SLOT_B_FIRST;
      OFS_B_SECOND:        slot = SLOT_B_SECOND;
      OFS_A_BANK0_GAIN:    slot = SLOT_GAIN;
      default:             slot = SLOT_NONE;
    endcase
  end

  // Register storage: fuse copy once after reset, then software writes.
  // A write in the copy cycle wins, since software intent is newer.
  always_comb begin
    for (int i = 0; i < OFFSET_REGS; i++) begin
      off_d[i] = off_q[i];
    end
    gain_d      = gain_q;
    loaded_d    = loaded_q;
    if (!loaded_q) begin
      off_d[0]    = {TRIM_RSV_CLR, FUSE_A_FIRST};
      off_d[1]    = {TRIM_RSV_CLR, FUSE_A_SECOND};
      off_d[2]    = {TRIM_RSV_CLR, FUSE_B_FIRST};
      off_d[3]    = {TRIM_RSV_CLR, FUSE_B_SECOND};
      gain_d      = {GAIN_RSV_CLR, FUSE_A_BANK0_GAIN};
      loaded_d    = 1'b1;
    end
    if (WR) begin
      unique case (slot)
        SLOT_A_FIRST:  off_d[0] = WDATA;
        SLOT_A_SECOND: off_d[1] = WDATA;
        SLOT_B_FIRST:  off_d[2] = WDATA;
        SLOT_B_SECOND: off_d[3] = WDATA;
        SLOT_GAIN:     gain_d = WDATA[GAIN_REG_W-1:0];
        default:       ;                  // Unmapped writes are dropped
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < OFFSET_REGS; i++) begin
        off_q[i] <= OFFSET_RESET;
      end
      gain_q      <= GAIN_RESET;
      loaded_q    <= 1'b0;  // Held as a set flag so the status pin is a flop
    end else if (CE) begin
      for (int i = 0; i < OFFSET_REGS; i++) begin
        off_q[i] <= off_d[i];
      end
      gain_q      <= gain_d;
      loaded_q    <= loaded_d;
    end
  end

  // Read data lands one cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    if (RD) begin
      unique case (slot)
        SLOT_A_FIRST:  rdata_d = off_q[0];
        SLOT_A_SECOND: rdata_d = off_q[1];
        SLOT_B_FIRST:  rdata_d = off_q[2];
        SLOT_B_SECOND: rdata_d = off_q[3];
        SLOT_GAIN:     rdata_d = {8'h00, gain_q};
        default:       rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else if (CE) begin
      rdata_q <= rdata_d;
    end
  end

  // Trim selection for the datapath. Combinations owned by other banks
  // (dual-mode core A first-input offsets, core A second input without phase90, single-mode gains) present zero here.
  always_comb begin
    a_off_d  = '0;
    b_off_d  = '0;
    a_gain_d = '0;
    if (FG_CAL_EN) begin
      if (!CORE_A_SECOND_INPUT && !DUAL_MODE) begin
        a_off_d = off_q[0][TRIM_MSB:TRIM_LSB];
      end else if (CORE_A_SECOND_INPUT && CORE_A_PHASE90) begin
        a_off_d = off_q[1][TRIM_MSB:TRIM_LSB];
      end
      if (!CORE_B_SECOND_INPUT) begin
        b_off_d = off_q[2][TRIM_MSB:TRIM_LSB];
      end else begin
        b_off_d = off_q[3][TRIM_MSB:TRIM_LSB];
      end
    end
    if (DUAL_MODE) begin
      a_gain_d = gain_q[GAIN_MSB:GAIN_LSB];
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      a_off_q  <= '0;
      b_off_q  <= '0;
      a_gain_q <= '0;
    end else if (CE) begin
      a_off_q  <= a_off_d;
      b_off_q  <= b_off_d;
      a_gain_q <= a_gain_d;
    end
  end

  assign RDATA             = rdata_q;
  assign CORE_A_OFFSET     = a_off_q;
  assign CORE_B_OFFSET     = b_off_q;
  assign CORE_A_BANK0_GAIN = a_gain_q;
  assign FUSE_LOADED       = loaded_q;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  property p_core_a_first;
    CE && FG_CAL_EN && !DUAL_MODE && !CORE_A_SECOND_INPUT
      |=> CORE_A_OFFSET == $past(off_q[0][TRIM_MSB:TRIM_LSB]);
  endproperty
  a_core_a_first: assert property (p_core_a_first)
    else $error("core A first input trim not applied");

  property p_core_a_second;
    CE && FG_CAL_EN && CORE_A_SECOND_INPUT && CORE_A_PHASE90
      |=> CORE_A_OFFSET == $past(off_q[1][TRIM_MSB:TRIM_LSB]);
  endproperty
  a_core_a_second: assert property (p_core_a_second)
    else $error("core A second input trim not applied");

  property p_core_b_first;
    CE && FG_CAL_EN && !CORE_B_SECOND_INPUT
      |=> CORE_B_OFFSET == $past(off_q[2][TRIM_MSB:TRIM_LSB]);
  endproperty
  a_core_b_first: assert property (p_core_b_first)
    else $error("core B first input trim not applied");

  property p_core_b_second;
    CE && FG_CAL_EN && CORE_B_SECOND_INPUT
      |=> CORE_B_OFFSET == $past(off_q[3][TRIM_MSB:TRIM_LSB]);
  endproperty
  a_core_b_second: assert property (p_core_b_second)
    else $error("core B second input trim not applied");

  sequence s_gain_write;
    CE && WR && ADDR == OFS_A_BANK0_GAIN;
  endsequence
  property p_gain_path;
    s_gain_write ##1 (CE && DUAL_MODE && !WR)
      |=> CORE_A_BANK0_GAIN == $past(WDATA[GAIN_MSB:GAIN_LSB], 2);
  endproperty
  a_gain_path: assert property (p_gain_path)
    else $error("written fine gain did not reach core A");

  property p_fuse_copy;
    CE && !loaded_q && !WR
      |=> FUSE_LOADED && off_q[0] == {TRIM_RSV_CLR, $past(FUSE_A_FIRST)}
          && gain_q == {GAIN_RSV_CLR, $past(FUSE_A_BANK0_GAIN)};
  endproperty
  a_fuse_copy: assert property (p_fuse_copy)
    else $error("fuse default not copied after reset");

  sequence s_trim_write;
    CE && WR && ADDR == OFS_B_SECOND;
  endsequence
  sequence s_trim_read;
    CE && RD && !WR && ADDR == OFS_B_SECOND;
  endsequence
  property p_full_width;
    s_trim_write ##1 s_trim_read |=> RDATA == $past(WDATA, 2);
  endproperty
  a_full_width: assert property (p_full_width)
    else $error("16-bit trim readback mismatch");

endmodule // trim_bank

/* File: tb/trim_bank_test.sv */
// Purpose: Self-checking bench for the offset and gain trim bank
// Assumes: Strobes and mode inputs change by NBA at the rising edge
// Notes:   A cycle model tracks registers, read data and trim outputs
`timescale 1ns/100ps
module trim_bank_test;
  import trim_bank_pkg::*;
  localparam logic [ADDR_W-1:0] MAP [8] = '{OFS_A_SINGLE_FIRST,
    OFS_A_SINGLE_SECOND, OFS_B_FIRST, OFS_B_SECOND, OFS_A_BANK0_GAIN,
    12'h0352, 12'h0000, 12'h0346};
  logic              clk_sys;
  logic              reset_n;
  logic              ce;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic [TRIM_W-1:0] fuse [4];
  logic [GAIN_W-1:0] fuse_gain;
  logic [4:0]        md;
  logic [TRIM_W-1:0] a_off;
  logic [TRIM_W-1:0] b_off;
  logic [GAIN_W-1:0] gain;
  logic              fuse_loaded;
  logic [31:0]       seed = 32'h2ff5_6d93;
  logic [15:0]       model [5];
  logic [15:0]       sp1 [5];
  logic [15:0]       sp2 [5];
  logic [4:0]        mp;
  logic [15:0]       exp_rd;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                cycles = 0;

  trim_bank trim_bank_i (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CE(ce),
    .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .FUSE_A_FIRST(fuse[0]), .FUSE_A_SECOND(fuse[1]),
    .FUSE_B_FIRST(fuse[2]), .FUSE_B_SECOND(fuse[3]),
    .FUSE_A_BANK0_GAIN(fuse_gain), .FG_CAL_EN(md[0]), .DUAL_MODE(md[1]),
    .CORE_A_SECOND_INPUT(md[2]), .CORE_A_PHASE90(md[3]),
    .CORE_B_SECOND_INPUT(md[4]), .CORE_A_OFFSET(a_off),
    .CORE_B_OFFSET(b_off), .CORE_A_BANK0_GAIN(gain),
    .FUSE_LOADED(fuse_loaded));

  // Free-running 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Mode bits: 0 cal, 1 dual, 2 core A second, 3 phase90, 4 core B second
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [15:0] exp_a(logic [4:0] m, logic [15:0] r [5]);
    if (m[0] && !m[1] && !m[2]) return {4'h0, r[0][11:0]};
    if (m[0] && m[2] && m[3]) return {4'h0, r[1][11:0]};
    return 16'h0000;
  endfunction

  function automatic logic [15:0] exp_b(logic [4:0] m, logic [15:0] r [5]);
    if (!m[0]) return 16'h0000;
    return {4'h0, m[4] ? r[3][11:0] : r[2][11:0]};
  endfunction

  function automatic logic [15:0] exp_g(logic [4:0] m, logic [15:0] r [5]);
    return m[1] ? {11'h000, r[4][4:0]} : 16'h0000;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // New random fuse defaults, reset held for 21 cycles
  task automatic do_reset();
    logic [31:0] r;
    @(posedge clk_sys);
    reset_n <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      r = xs();
      fuse[i] <= r[11:0];
      model[i] = {4'h0, r[11:0]};
    end
    r = xs();
    fuse_gain <= r[4:0];
    model[4] = {11'h000, r[4:0]};
    repeat (20) @(posedge clk_sys);
    #1;
    chk({4'h0, a_off} | {4'h0, b_off} | rdata, 16'h0000);
    chk({15'h0000, fuse_loaded}, 16'h0000);
    @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask

  // Back-to-back random accesses and modes, checked every cycle
  task automatic run(input int n);
    logic [31:0] r;
    logic [2:0]  k;
    repeat (3) @(posedge clk_sys);
    #1;
    chk({15'h0000, fuse_loaded}, 16'h0001);
    sp1 = model;
    sp2 = model;
    mp = md;
    exp_rd = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      r = xs();
      k = r[4:2];
      wr <= (r[1:0] == 2'd1);
      rd <= r[1];
      addr <= MAP[k];
      wdata <= r[31:16];
      md <= r[9:5];
      #1;
      chk(rdata, exp_rd);
      chk({4'h0, a_off}, exp_a(mp, sp2));
      chk({4'h0, b_off}, exp_b(mp, sp2));
      chk({11'h000, gain}, exp_g(mp, sp2));
      sp2 = sp1;
      exp_rd = (r[1] && k < 5) ? model[k] : 16'h0000;
      if (r[1:0] == 2'd1 && k < 5)
        model[k] = (k == 4) ? {8'h00, r[23:16]} : r[31:16];
      sp1 = model;
      mp = r[9:5];
    end
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // Hang guard, well above the planned run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {ce, wr, rd, reset_n, md, fuse_gain} = '0;
    {addr, wdata} = '0;
    for (int i = 0; i < 4; i++) fuse[i] = '0;
    ce = 1'b1;
    do_reset();
    run(2000);
    $display("test random traffic done");
    // A write with the clock enable low must be lost
    @(posedge clk_sys);
    ce <= 1'b0;
    wr <= 1'b1;
    addr <= OFS_B_FIRST;
    wdata <= ~model[2];
    @(posedge clk_sys);
    ce <= 1'b1;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk(rdata, model[2]);
    $display("test clock enable done");
    do_reset();
    run(2000);
    $display("test second reset done");
    conclude();
  end
endmodule // trim_bank_test
